// File: include/fic_pkg.sv
// Constants and types for the fault indicator and configuration loader
package fic_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam longint unsigned PWM_PERIOD_NS = 64'd62_500_000;
   localparam int unsigned PWM_CYC = int'(PWM_PERIOD_NS / CLK_PERIOD_NS);
   localparam longint unsigned GATE_NS = 64'd250_000_000;
   localparam int unsigned GATE_CYC = int'(GATE_NS / CLK_PERIOD_NS);
   localparam int unsigned BUS_BIT_NS = 10_000;
   localparam int unsigned QTR_CYC = BUS_BIT_NS / (4 * CLK_PERIOD_NS);
   localparam int unsigned PWM_W = 21;
   localparam int unsigned GATE_W = 23;

   // ==========================================================
   // Indicator duty, percent of period spent low
   localparam int unsigned AMP_LOW_PCT = 75;
   localparam int unsigned FREQ_LOW_PCT = 50;

   // ==========================================================
   // Frequency limit
   localparam int unsigned LOW_RES_MAX_HZ = 1000;
   localparam logic [8:0] LOW_RES_EDGES = 9'(LOW_RES_MAX_HZ * (GATE_NS / 64'd1_000_000) / 1000);
   localparam logic [8:0] EDGE_SAT = 9'h1ff;
   localparam logic [3:0] RES_SPLIT = 4'hc;

   // ==========================================================
   // Serial EEPROM transfer
   localparam logic [7:0] DEV_WR = 8'ha0;
   localparam logic [7:0] DEV_RD = 8'ha1;
   localparam logic [7:0] WORD_ADDR = 8'h00;
   localparam logic [6:0] LAST_BYTE = 7'h7f;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam int unsigned KEEP_BYTES = 2;
   localparam int unsigned RES_BYTE = 0;
   localparam int unsigned RES_LSB = 0;
   localparam int unsigned FMAX_BYTE = 1;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      LD_IDLE = 4'h0,
      LD_START = 4'h1,
      LD_TX = 4'h3,
      LD_RSTART = 4'h2,
      LD_RX = 4'h6,
      LD_STOP = 4'h7,
      LD_DONE = 4'h5,
      LD_FAIL = 4'h4
   } fic_ld_t;

   typedef enum logic [1:0] {
      FM_NONE = 2'h0,
      FM_AMP = 2'h1,
      FM_FREQ = 2'h2,
      FM_CFG = 2'h3
   } fic_mode_t;

   typedef struct packed {
      logic cfg;
      logic amp;
      logic freq;
   } fic_fault_t;

endpackage

// File: hdl/fic_pwm.sv
// Indicator waveform generator: steady levels or 16 Hz PWM
`timescale 1ns/100ps
module fic_pwm #(
   parameter int unsigned PERIOD = fic_pkg::PWM_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire fic_pkg::fic_mode_t mode,
   output logic level_q
);

   localparam logic [fic_pkg::PWM_W-1:0] LAST = fic_pkg::PWM_W'(PERIOD - 1);
   localparam logic [fic_pkg::PWM_W-1:0] LOW_AMP = fic_pkg::PWM_W'(PERIOD * fic_pkg::AMP_LOW_PCT / 100);
   localparam logic [fic_pkg::PWM_W-1:0] LOW_FREQ = fic_pkg::PWM_W'(PERIOD * fic_pkg::FREQ_LOW_PCT / 100);

   logic [fic_pkg::PWM_W-1:0] cnt_q;

   // ==========================================================
   // Period counter, free running so a mode change never stalls it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // ==========================================================
   // Output level
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_q <= 1'b1;
      end else begin
         unique case (mode)
            fic_pkg::FM_NONE: level_q <= 1'b1;
            fic_pkg::FM_AMP: level_q <= (cnt_q >= LOW_AMP);
            fic_pkg::FM_FREQ: level_q <= (cnt_q >= LOW_FREQ);
            fic_pkg::FM_CFG: level_q <= 1'b0;
         endcase
      end
   end

endmodule // fic_pwm

// File: hdl/fic_top.sv
// Fault indicator with power-up configuration load from serial EEPROM
`timescale 1ns/100ps
module fic_top #(
   parameter int unsigned PWM_CYCLES = fic_pkg::PWM_CYC,
   parameter int unsigned GATE_CYCLES = fic_pkg::GATE_CYC,
   parameter int unsigned QTR_CYCLES = fic_pkg::QTR_CYC
) (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic AMP_LOW,
   input wire logic SIG_ZC,
   input wire logic SDA_IN,
   output logic SCL,
   output logic SDA_OUT,
   output logic SDA_OE,
   output logic FAULT_B,
   output logic CFG_READY,
   output logic [3:0] RES_CODE
);

   localparam int unsigned NPIN = 3;
   localparam int unsigned P_AMP = 0;
   localparam int unsigned P_ZC = 1;
   localparam int unsigned P_SDA = 2;
   localparam logic [5:0] QTR_LAST = 6'(QTR_CYCLES - 1);
   localparam logic [fic_pkg::GATE_W-1:0] GATE_LAST = fic_pkg::GATE_W'(GATE_CYCLES - 1);

   logic [NPIN-1:0] pin_in;
   logic [NPIN-1:0] filt_q;
   fic_pkg::fic_ld_t st_q;
   logic [5:0] qcnt_q;
   logic qtick;
   logic [1:0] ph_q;
   logic [3:0] bitn_q;
   logic [1:0] txsel_q;
   logic [6:0] bcnt_q;
   logic [7:0] shr_q;
   logic [7:0] sum_q;
   logic nack_q;
   logic [7:0] keep_q [fic_pkg::KEEP_BYTES];
   logic [7:0] tx_byte;
   logic scl_d;
   logic sda_low_d;
   logic zc_prev_q;
   logic [fic_pkg::GATE_W-1:0] gate_q;
   logic [8:0] edges_q;
   logic [8:0] limit;
   logic freq_flt_q;
   fic_pkg::fic_fault_t flt;
   fic_pkg::fic_mode_t mode;

   assign pin_in = {SDA_IN, SIG_ZC, AMP_LOW};

   // ==========================================================
   // Pin synchronisers: a change counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         logic [2:0] s_q;
         always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
               s_q <= 3'h7;
               filt_q[gi] <= 1'b1;
            end else begin
               s_q <= {s_q[1:0], pin_in[gi]};
               if (s_q[1] == s_q[2]) begin
                  filt_q[gi] <= s_q[2];
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Quarter-bit timebase for the EEPROM bus
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         qcnt_q <= '0;
      end else if (qcnt_q == QTR_LAST) begin
         qcnt_q <= '0;
      end else begin
         qcnt_q <= qcnt_q + 1'b1;
      end
   end
   assign qtick = (qcnt_q == QTR_LAST);

   always_comb begin
      unique case (txsel_q)
         2'h0: tx_byte = fic_pkg::DEV_WR;
         2'h1: tx_byte = fic_pkg::WORD_ADDR;
         default: tx_byte = fic_pkg::DEV_RD;
      endcase
   end

   // ==========================================================
   // Load sequencer: address, word pointer, repeated start, 128-byte read
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         st_q <= fic_pkg::LD_IDLE;
         ph_q <= '0;
         bitn_q <= '0;
         txsel_q <= '0;
         bcnt_q <= '0;
         nack_q <= 1'b0;
      end else if (qtick) begin
         ph_q <= ph_q + 1'b1;
         if (ph_q == 2'h2 && st_q == fic_pkg::LD_TX && bitn_q == fic_pkg::ACK_BIT) begin
            nack_q <= filt_q[P_SDA];
         end
         if (ph_q == 2'h3) begin
            unique case (st_q)
               fic_pkg::LD_IDLE: st_q <= fic_pkg::LD_START;
               fic_pkg::LD_START, fic_pkg::LD_RSTART: begin
                  st_q <= fic_pkg::LD_TX;
                  bitn_q <= '0;
               end
               fic_pkg::LD_TX: begin
                  if (bitn_q == fic_pkg::ACK_BIT) begin
                     bitn_q <= '0;
                     if (nack_q) begin
                        st_q <= fic_pkg::LD_STOP;
                     end else if (txsel_q == 2'h1) begin
                        st_q <= fic_pkg::LD_RSTART;
                        txsel_q <= 2'h2;
                     end else if (txsel_q == 2'h0) begin
                        txsel_q <= 2'h1;
                     end else begin
                        st_q <= fic_pkg::LD_RX;
                     end
                  end else begin
                     bitn_q <= bitn_q + 1'b1;
                  end
               end
               fic_pkg::LD_RX: begin
                  if (bitn_q == fic_pkg::ACK_BIT) begin
                     bitn_q <= '0;
                     bcnt_q <= bcnt_q + 1'b1;
                     if (bcnt_q == fic_pkg::LAST_BYTE) begin
                        st_q <= fic_pkg::LD_STOP;
                     end
                  end else begin
                     bitn_q <= bitn_q + 1'b1;
                  end
               end
               fic_pkg::LD_STOP: begin
                  // Any refusal or a nonzero byte sum marks the image bad
                  if (nack_q || sum_q != 8'h00) begin
                     st_q <= fic_pkg::LD_FAIL;
                  end else begin
                     st_q <= fic_pkg::LD_DONE;
                  end
               end
               fic_pkg::LD_DONE, fic_pkg::LD_FAIL: st_q <= st_q;
            endcase
         end
      end
   end

   // ==========================================================
   // Read data shift, checksum and kept configuration bytes
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         shr_q <= '0;
         sum_q <= '0;
      end else if (qtick && st_q == fic_pkg::LD_RX && bitn_q != fic_pkg::ACK_BIT) begin
         if (ph_q == 2'h2) begin
            shr_q <= {shr_q[6:0], filt_q[P_SDA]};
         end
         if (ph_q == 2'h3 && bitn_q == 4'h7) begin
            sum_q <= sum_q + shr_q;
         end
      end
   end

   generate
      for (gi = 0; gi < fic_pkg::KEEP_BYTES; gi++) begin : g_keep
         always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
               keep_q[gi] <= '0;
            end else if (qtick && st_q == fic_pkg::LD_RX && ph_q == 2'h3 && bitn_q == 4'h7
                         && bcnt_q == 7'(gi)) begin
               keep_q[gi] <= shr_q;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Bus drive; SDA is open drain, only ever pulled low
   always_comb begin
      scl_d = 1'b1;
      sda_low_d = 1'b0;
      unique case (st_q)
         fic_pkg::LD_START, fic_pkg::LD_RSTART: begin
            scl_d = (ph_q == 2'h1 || ph_q == 2'h2);
            sda_low_d = ph_q[1];
         end
         fic_pkg::LD_TX: begin
            scl_d = (ph_q == 2'h1 || ph_q == 2'h2);
            sda_low_d = (bitn_q != fic_pkg::ACK_BIT) && !tx_byte[3'(4'h7 - bitn_q)];
         end
         fic_pkg::LD_RX: begin
            scl_d = (ph_q == 2'h1 || ph_q == 2'h2);
            // Acknowledge every byte but the last, which ends the read
            sda_low_d = (bitn_q == fic_pkg::ACK_BIT) && (bcnt_q != fic_pkg::LAST_BYTE);
         end
         fic_pkg::LD_STOP: begin
            scl_d = (ph_q != 2'h0);
            sda_low_d = !ph_q[1];
         end
         fic_pkg::LD_IDLE, fic_pkg::LD_DONE, fic_pkg::LD_FAIL: begin
            scl_d = 1'b1;
            sda_low_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         SCL <= 1'b1;
         SDA_OE <= 1'b0;
         SDA_OUT <= 1'b0;
      end else begin
         SCL <= scl_d;
         SDA_OE <= sda_low_d;
         SDA_OUT <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         CFG_READY <= 1'b0;
         RES_CODE <= '0;
      end else begin
         CFG_READY <= (st_q == fic_pkg::LD_DONE);
         RES_CODE <= keep_q[fic_pkg::RES_BYTE][fic_pkg::RES_LSB +: 4];
      end
   end

   // ==========================================================
   // Frequency monitor: signal edges counted over a fixed gate
   assign limit = (RES_CODE < fic_pkg::RES_SPLIT) ? fic_pkg::LOW_RES_EDGES
                                                  : {1'b0, keep_q[fic_pkg::FMAX_BYTE]};

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         zc_prev_q <= 1'b1;
         gate_q <= '0;
         edges_q <= '0;
         freq_flt_q <= 1'b0;
      end else begin
         zc_prev_q <= filt_q[P_ZC];
         if (!CFG_READY) begin
            gate_q <= '0;
            edges_q <= '0;
            freq_flt_q <= 1'b0;
         end else if (gate_q == GATE_LAST) begin
            gate_q <= '0;
            edges_q <= '0;
            freq_flt_q <= (edges_q > limit);
         end else begin
            gate_q <= gate_q + 1'b1;
            if (filt_q[P_ZC] && !zc_prev_q && edges_q != fic_pkg::EDGE_SAT) begin
               edges_q <= edges_q + 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Fault priority and indicator
   always_comb begin
      flt.cfg = (st_q == fic_pkg::LD_FAIL);
      flt.amp = CFG_READY && filt_q[P_AMP];
      flt.freq = CFG_READY && freq_flt_q;
      if (flt.cfg) begin
         mode = fic_pkg::FM_CFG;
      end else if (flt.amp) begin
         mode = fic_pkg::FM_AMP;
      end else if (flt.freq) begin
         mode = fic_pkg::FM_FREQ;
      end else begin
         mode = fic_pkg::FM_NONE;
      end
   end

   fic_pwm #(
      .PERIOD(PWM_CYCLES)
   ) u_pwm (
      .clk(CLOCK),
      .rst_b(RST_B),
      .mode(mode),
      .level_q(FAULT_B)
   );

endmodule // fic_top

// File: bench/fic_sva.sv
// Checker for indicator levels and configuration load at the top ports
`timescale 1ns/100ps
module fic_sva #(
   parameter int unsigned PWM_CYCLES = fic_pkg::PWM_CYC,
   parameter int unsigned GATE_CYCLES = fic_pkg::GATE_CYC
) (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic AMP_LOW,
   input wire logic SCL,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic FAULT_B,
   input wire logic CFG_READY,
   input wire logic [3:0] RES_CODE
);
   localparam int PW = PWM_CYCLES + 8;
   localparam int LOW_MAX = PWM_CYCLES * 3 / 4;
   localparam int HI_MAX = PWM_CYCLES / 4;
   int lo_run_q;
   int hi_run_q;
   int amp_run_q;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);
   // ==========================================================
   // Run lengths of indicator levels and of the amplitude input
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         lo_run_q <= 0;
         hi_run_q <= 0;
      end else begin
         lo_run_q <= FAULT_B ? 0 : lo_run_q + 1;
         hi_run_q <= FAULT_B ? hi_run_q + 1 : 0;
      end
   end
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) amp_run_q <= 0;
      else amp_run_q <= AMP_LOW ? amp_run_q + 1 : 0;
   end
   // ==========================================================
   // Properties
   a_reset_vals: assert property ($rose(RST_B) |-> SCL && !SDA_OE && FAULT_B && !CFG_READY && RES_CODE == 4'h0)
      else $error("outputs not at reset values");
   a_ready_stays: assert property (CFG_READY |=> CFG_READY)
      else $error("ready dropped");
   a_code_frozen: assert property (CFG_READY |=> $stable(RES_CODE))
      else $error("resolution code changed");
   a_sda_pull_only: assert property (SDA_OE |-> !SDA_OUT)
      else $error("data wire driven high");
   a_cfg_fail_holds: assert property (!CFG_READY && !FAULT_B |=> !FAULT_B && !CFG_READY)
      else $error("failed load did not hold low");
   a_rise_needs_ready: assert property ($rose(FAULT_B) |-> CFG_READY)
      else $error("indicator rose without a good load");
   a_low_run_cap: assert property (CFG_READY |-> lo_run_q <= LOW_MAX)
      else $error("indicator low too long");
   a_amp_high_short: assert property (CFG_READY && amp_run_q > hi_run_q + 8 |-> hi_run_q <= HI_MAX)
      else $error("amplitude pattern high too long");
   a_amp_pulses: assert property (CFG_READY && amp_run_q == 8 |-> ##[0:PW] (!FAULT_B || !AMP_LOW))
      else $error("amplitude fault never pulled low");
   c_amp_fall: cover property (CFG_READY && amp_run_q > 8 ##1 $fell(FAULT_B));
   c_cfg_fail: cover property (!CFG_READY && $fell(FAULT_B));
   c_ready: cover property ($rose(CFG_READY));
endmodule // fic_sva

// File: bench/fic_eeprom.sv
// Behavioural serial configuration memory answering the loader
`timescale 1ns/100ps
module fic_eeprom (
   input wire logic scl,
   input wire logic sda,
   input wire logic nack_all,
   output logic pull_low
);
   logic [7:0] mem [0:127];
   logic [7:0] sh;
   logic [6:0] ptr;
   logic act;
   logic rd;
   logic first;
   int bitn;
   // ==========================================================
   // Image is present before the loader ever runs
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'h00;
      mem[0] = 8'h04;
      mem[1] = 8'hfc;
      pull_low = 1'b0;
      act = 1'b0;
      rd = 1'b0;
      ptr = 7'h00;
   end
   always @(negedge sda) if (scl) begin
      act = 1'b1;
      rd = 1'b0;
      first = 1'b1;
      bitn = -1;
   end
   always @(posedge sda) if (scl) act = 1'b0;
   always @(posedge scl) begin
      if (act && bitn < 8) sh = {sh[6:0], sda};
      else if (act && rd && sda) act = 1'b0;
   end
   // Changes only while the clock is low, so it never fakes a start or stop
   always @(negedge scl) if (act) begin
      bitn = (bitn == 8) ? 0 : bitn + 1;
      if (bitn == 8 && rd) begin
         pull_low = 1'b0;
         ptr = ptr + 7'h01;
      end else if (bitn == 8) begin
         pull_low = !nack_all;
         if (first) rd = sh[0];
         else ptr = sh[6:0];
         first = 1'b0;
      end else if (rd) pull_low = !mem[ptr][7 - bitn];
      else pull_low = 1'b0;
   end
endmodule // fic_eeprom

// File: bench/tb.sv
// Testbench for the fault indicator and configuration load
`timescale 1ns/100ps
module tb;
   localparam int unsigned P = 400;
   localparam int unsigned G = 2000;
   // Short bus quarter so two full loads fit the run budget
   localparam int unsigned Q = 6;
   logic CLOCK, RST_B, AMP_LOW, SIG_ZC, nack_all;
   logic SCL, SDA_OUT, SDA_OE, FAULT_B, CFG_READY, sda_low;
   logic [3:0] RES_CODE;
   // Pull-up on the shared data wire
   wire logic sda_wire = SDA_OE ? SDA_OUT : !sda_low;
   int bad_count = 0;
   int comparisons = 0;
   int zc_half = 0;
   int zc_cnt = 0;
   fic_top #(.PWM_CYCLES(P), .GATE_CYCLES(G), .QTR_CYCLES(Q)) fic_top_i (.CLOCK(CLOCK), .RST_B(RST_B),
      .AMP_LOW(AMP_LOW), .SIG_ZC(SIG_ZC), .SDA_IN(sda_wire), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
      .FAULT_B(FAULT_B), .CFG_READY(CFG_READY), .RES_CODE(RES_CODE));
   fic_eeprom fic_eeprom_i (.scl(SCL), .sda(sda_wire), .nack_all(nack_all), .pull_low(sda_low));
   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t ns %s: got %0h, want %0h", $time, what, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask
   task automatic reset_dut(input logic n);
      RST_B = 1'b0;
      nack_all = n;
      cyc(12);
      RST_B = 1'b1;
   endtask
   // Two whole periods, so exactly two falls whatever the phase
   task automatic measure(output int l, output int f);
      logic prev;
      l = 0;
      f = 0;
      prev = FAULT_B;
      repeat (2 * P) begin
         cyc(1);
         l += (FAULT_B === 1'b0);
         f += (prev === 1'b1 && FAULT_B === 1'b0);
         prev = FAULT_B;
      end
   endtask
   // A frequency fault holds for one window, so let two windows pass
   task automatic run_pwm(input logic amp, input int half, output int l, output int f);
      AMP_LOW = amp;
      zc_half = half;
      cyc(2 * G + 50);
      measure(l, f);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_cfg_fail();
      int i, l, f;
      reset_dut(1'b1);
      AMP_LOW = 1'b1;
      for (i = 0; i < 4000 && FAULT_B !== 1'b0; i++) cyc(1);
      check(32'(FAULT_B), 32'h0, "fail level");
      measure(l, f);
      check(32'(l), 32'(2 * P), "fail steady");
      check(32'(CFG_READY), 32'h0, "fail ready");
   endtask
   task automatic t_load(input logic [3:0] code);
      int i;
      AMP_LOW = 1'b0;
      reset_dut(1'b0);
      cyc(1000);
      check(32'(FAULT_B), 32'h1, "idle during load");
      for (i = 0; i < 40000 && CFG_READY !== 1'b1; i++) cyc(1);
      check(32'(CFG_READY), 32'h1, "load done");
      check(32'(RES_CODE), 32'(code), "res code");
   endtask
   task automatic t_no_fault();
      int l, f;
      run_pwm(1'b0, 0, l, f);
      check(32'(l), 32'h0, "no fault");
   endtask
   task automatic t_amp();
      int l, f;
      run_pwm(1'b1, 0, l, f);
      check(32'(l), 32'(P * 3 / 2), "amp duty");
      check(32'(f), 32'h2, "amp rate");
   endtask
   task automatic t_freq();
      int l, f;
      run_pwm(1'b0, 3, l, f);
      check(32'(l), 32'(P), "freq duty");
      check(32'(f), 32'h2, "freq rate");
   endtask
   task automatic t_both();
      int l, f;
      run_pwm(1'b1, 3, l, f);
      check(32'(l), 32'(P * 3 / 2), "both duty");
   endtask
   task automatic t_slow();
      int l, f;
      run_pwm(1'b0, 10, l, f);
      check(32'(l), 32'h0, "slow no fault");
   endtask
   // Code 12 and up takes the limit from byte 1; byte 2 keeps the sum zero
   task automatic t_high_res();
      int l, f;
      fic_eeprom_i.mem[0] = 8'h0c;
      fic_eeprom_i.mem[1] = 8'h40;
      fic_eeprom_i.mem[2] = 8'hb4;
      t_load(4'hc);
      run_pwm(1'b0, 10, l, f);
      check(32'(l), 32'(P), "byte limit duty");
      check(32'(f), 32'h2, "byte limit rate");
   endtask
   // ==========================================================
   // Clock, signal source, sequence and watchdog
   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end
   initial forever begin
      @(posedge CLOCK);
      zc_cnt++;
      if (zc_half != 0 && zc_cnt >= zc_half) begin
         #1 SIG_ZC = ~SIG_ZC;
         zc_cnt = 0;
      end
   end
   initial begin
      RST_B = 1'b0;
      AMP_LOW = 1'b0;
      SIG_ZC = 1'b0;
      nack_all = 1'b0;
      t_cfg_fail();
      t_load(4'h4);
      t_no_fault();
      t_amp();
      t_freq();
      t_both();
      t_slow();
      t_high_res();
      end_sim();
   end
   // Each load takes about 28k cycles; the whole run about 87k
   initial begin
      repeat (95000) @(posedge CLOCK);
      bad_count++;
      $display("[FAIL] %0t ns watchdog expired", $time);
      end_sim();
   end
endmodule // tb
bind fic_top fic_sva #(.PWM_CYCLES(PWM_CYCLES), .GATE_CYCLES(GATE_CYCLES)) fic_sva_i (.CLOCK(CLOCK),
   .RST_B(RST_B), .AMP_LOW(AMP_LOW), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .FAULT_B(FAULT_B),
   .CFG_READY(CFG_READY), .RES_CODE(RES_CODE));
